// ---- logic/compat_consts.svh ----
// Purpose: timing-free constants for the compatibility-mode gating block
// Assumes: included by bare name from the design files
// Notes: offsets, field positions, reset values and channel numbers
`ifndef COMPAT_CONSTS_SVH
`define COMPAT_CONSTS_SVH
// Register offsets on the plain register port
`define OFS_STATUS 4'h0
`define OFS_MASK 4'h1
`define OFS_CONTROL 4'h2
`define OFS_PREFIX 4'h3
`define OFS_ATR_SLOT 4'h4
`define OFS_MODE 4'h5
// Control register bits
`define CTL_INHIBIT_LOGOUT_STOP_BIT 6
`define CTL_STEP_EN_BIT 0
// Status bit positions
`define ST_ENTER 0
`define ST_LEAVE 1
`define ST_CHECKSTOP 2
`define ST_INVALID_OP 3
// Reset values
`define CONTROL_RESET 8'h00
`define MASK_RESET 4'h0
`define ATR_RESET 16'h0000
// Interruption code field of the status word, bits 16-19
`define PSW_FIELD_LO 16
`define PSW_FIELD_HI 19
// Channel numbers
`define CHAN_MPX 4'h0
`define CHAN_SEL_MAX 4'h3
`endif

// ---- logic/compat_pkg.sv ----
// Purpose: types for the compatibility-mode gating block
// Assumes: nothing
// Notes: constants live in compat_consts.svh
package compat_pkg;
  // Channel addressing request and answer
  typedef struct packed {
    logic valid;
    logic [1:0] element;
    logic [3:0] channel;
  } chan_req_t;
  typedef enum logic [1:0] {
    CH_OPERATIONAL = 2'b00,
    CH_NOT_OPER = 2'b01,
    CH_INVALID = 2'b10
  } chan_resp_t;
  // Storage protection check
  typedef struct packed {
    logic valid;
    logic [3:0] prot_key;
    logic [3:0] stor_key;
  } key_req_t;
  // Mode state machine
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ENTER = 2'b01,
    MODE_COMPAT = 2'b10
  } mode_state_t;
endpackage

// ---- logic/compat_opcode_check.sv ----
// Purpose: flags op codes that may not run in compatibility mode
// Assumes: op code presented with a decode strobe
// Notes: result is registered
`timescale 1ns/1ps
module compat_opcode_check
  import compat_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Decode request
  input wire logic dec_valid,
  input wire logic [7:0] opcode,
  input wire logic compat,
  // Result
  output logic reject_q
);
  // Set of op codes barred in compatibility mode
  function automatic logic barred(input logic [7:0] op);
    case (op)
      8'h01, 8'h02, 8'h03, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
      8'h52, 8'h9a, 8'h9b, 8'ha0, 8'ha1, 8'hd8: barred = 1'b1;
      default: barred = 1'b0;
    endcase
  endfunction

  // Registered reject pulse
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      reject_q <= 1'b0;
    end else begin
      reject_q <= dec_valid && compat && barred(opcode); // [RULE_07]
    end
  end
endmodule

// ---- logic/compat_key_check.sv ----
// Purpose: storage key match rule, mode dependent
// Assumes: keys presented with a valid strobe
// Notes: result is registered one cycle later
`timescale 1ns/1ps
module compat_key_check
  import compat_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Request
  input key_req_t req,
  input wire logic compat,
  // Result
  output logic done_q,
  output logic match_q
);
  // Match decision
  function automatic logic key_ok(input key_req_t r, input logic c);
    if (c) begin
      key_ok = (r.prot_key == 4'h0) || (r.prot_key == r.stor_key); // [RULE_12]
    end else begin
      key_ok = (r.prot_key == 4'h0) || (r.stor_key == 4'h0) || (r.prot_key == r.stor_key); // [RULE_11]
    end
  endfunction

  // Register the answer
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      done_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      done_q <= req.valid;
      match_q <= req.valid && key_ok(req, compat);
    end
  end
endmodule

// ---- logic/compat_mode_ctrl.sv ----
// Purpose: compatibility-mode gating for a computing element and its I/O control element
// Assumes: all inputs synchronous to CLK_SYS; NRST is the power-on reset
// Notes: registers on a plain port, read data one cycle after the read strobe
// Summary of operation
// RULE_01 - Compat mode behaves as if inhibit_logout_stop control bit 6 were set.
// RULE_02 - Prefix base register stepping is suppressed in compat mode.
// RULE_03 - No logout_stop_signal goes to any storage_element in compat mode.
// RULE_04 - Entering compat mode clears the logical prefix base register.
// RULE_05 - Entering compat mode loads physical prefix from translator register 1 slot 1.
// RULE_06 - Lockout or element-stopped becomes checkstop, not interruption, in compat mode.
// RULE_07 - Fourteen extended op codes are invalid in compat mode.
// RULE_08 - Status word bits 16-19 are interruption code, not mask, in compat mode.
// RULE_09 - Only channels 0 to 3 of the first io_control_element operate.
// RULE_10 - Second element channels not operational, third element channels invalid.
// RULE_11 - Normal mode: zero protection or storage key, or equal keys, match.
// RULE_12 - Compat mode: only zero protection key is wildcard.
// RULE_13 - The first element's I/O processor is held stopped in compat mode.
// RULE_14 - Program load and status restart force state three, clearing compat mode.
// RULE_15 - Direct control passes through unchanged in both modes.
// RULE_16 - Pushbutton toggles the mode; lamp lit while active.
// RULE_17 - Power-on reset, external start, state two or three clear the mode.
// RULE_18 - Barred op code raises the ordinary invalid-operation exception.
// RULE_19 - Mode changes take effect at the next instruction boundary.
`timescale 1ns/1ps
`include "compat_consts.svh"
module compat_mode_ctrl
  import compat_pkg::*;
#(
  parameter int PREFIX_W = 16
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Panel and reset events
  input wire logic MODE_BUTTON,
  input wire logic EXT_START,
  input wire logic STATE_TWO,
  input wire logic STATE_THREE,
  input wire logic SYS_LOAD,
  input wire logic SYS_RESTART,
  output logic MODE_LAMP,
  // Instruction boundary and decode
  input wire logic INSTR_BOUNDARY,
  input wire logic DEC_VALID,
  input wire logic [7:0] OPCODE,
  output logic INVALID_OP_EXC,
  // Status word interpretation
  input wire logic [31:0] PSW_IN,
  output logic [3:0] SYS_MASK_EXT,
  output logic [3:0] INT_CODE_EXT,
  // Prefix base register stepping
  input wire logic PREFIX_STEP_REQ,
  output logic [PREFIX_W-1:0] PREFIX_LOGICAL,
  output logic [PREFIX_W-1:0] PREFIX_PHYSICAL,
  // Logout stop and storage faults
  input wire logic LOGOUT_STOP_REQ,
  output logic LOGOUT_STOP_OUT,
  input wire logic PREF_LOCKOUT,
  input wire logic STOR_STOPPED,
  output logic STOR_FAULT_INT,
  output logic CHECKSTOP,
  // Channel addressing
  input chan_req_t CHAN_REQ,
  output logic CHAN_RESP_VALID,
  output chan_resp_t CHAN_RESP,
  // Storage protection
  input key_req_t KEY_REQ,
  output logic KEY_DONE,
  output logic KEY_MATCH,
  // I/O processor and direct control
  output logic IOP_STOP,
  input wire logic [7:0] DIRECT_CTL_IN,
  output logic [7:0] DIRECT_CTL_OUT,
  // Interrupt
  output logic IRQ
);
  mode_state_t state_q;
  logic compat_flag_q;
  logic compat_q;
  logic [7:0] control_q;
  logic [3:0] mask_q;
  logic [3:0] status_q;
  logic [PREFIX_W-1:0] atr_slot_q;
  logic [PREFIX_W-1:0] prefix_log_q;
  logic [PREFIX_W-1:0] prefix_phys_q;
  logic checkstop_q;
  logic fault_int_q;
  logic logout_q;
  logic chan_valid_q;
  chan_resp_t chan_resp_q;
  logic [7:0] direct_q;
  logic [31:0] rdata_q;
  logic [3:0] sys_mask_q;
  logic [3:0] int_code_q;
  logic reject;
  logic clear_evt;
  logic wr_status;
  logic inhibit_logout_stop_eff;
  logic [3:0] events;
  logic stor_fault;
  logic step_ok;
  logic enter_evt;
  logic leave_evt;

  // Prefix base register advance, shared by both halves of the register pair
  function automatic logic [PREFIX_W-1:0] prefix_next(input logic [PREFIX_W-1:0] p);
    prefix_next = p + PREFIX_W'(1);
  endfunction

  // Events that clear the mode
  assign clear_evt = EXT_START || STATE_TWO || STATE_THREE || SYS_LOAD || SYS_RESTART; // [RULE_17] [RULE_14]
  assign wr_status = REG_WR && (REG_ADDR == `OFS_STATUS);

  // Storage fault from either source, seen by checkstop, interruption and status
  assign stor_fault = PREF_LOCKOUT || STOR_STOPPED;

  // Panel flag; toggles on the button, cleared by the reset events
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      compat_flag_q <= 1'b0; // [RULE_17]
    end else if (clear_evt) begin
      compat_flag_q <= 1'b0; // [RULE_17]
    end else if (MODE_BUTTON) begin
      compat_flag_q <= ~compat_flag_q; // [RULE_16]
    end
  end

  // Mode state machine; effective mode follows the flag at an instruction boundary, and is also left on a clear event seen while the flag is already clear
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      state_q <= MODE_NORMAL;
      compat_q <= 1'b0;
    end else begin
      case (state_q)
        MODE_NORMAL: begin
          if (compat_flag_q && INSTR_BOUNDARY) begin
            state_q <= MODE_ENTER; // [RULE_19]
            compat_q <= 1'b1;
          end
        end
        MODE_ENTER: begin
          state_q <= compat_flag_q ? MODE_COMPAT : MODE_NORMAL;
          compat_q <= compat_flag_q;
        end
        MODE_COMPAT: begin
          if (!compat_flag_q && (INSTR_BOUNDARY || clear_evt)) begin
            state_q <= MODE_NORMAL; // [RULE_19]
            compat_q <= 1'b0;
          end
        end
        default: begin
          state_q <= MODE_NORMAL;
          compat_q <= 1'b0;
        end
      endcase
    end
  end

  assign MODE_LAMP = compat_flag_q; // [RULE_16]

  // Effective inhibit: software bit or compat mode
  assign inhibit_logout_stop_eff = control_q[`CTL_INHIBIT_LOGOUT_STOP_BIT] || compat_q; // [RULE_01]

  // Software control, mask and translator slot registers
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      control_q <= `CONTROL_RESET;
      mask_q <= `MASK_RESET;
      atr_slot_q <= PREFIX_W'(`ATR_RESET);
    end else if (REG_WR) begin
      case (REG_ADDR)
        `OFS_CONTROL: control_q <= REG_WDATA[7:0];
        `OFS_MASK: mask_q <= REG_WDATA[3:0];
        `OFS_ATR_SLOT: atr_slot_q <= REG_WDATA[PREFIX_W-1:0];
        default: ;
      endcase
    end
  end

  // Stepping needs the enable bit and no inhibit, from software or from the mode
  assign step_ok = PREFIX_STEP_REQ && !inhibit_logout_stop_eff && control_q[`CTL_STEP_EN_BIT]; // [RULE_02]

  // Prefix base registers: load on entry, step only when not inhibited
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      prefix_log_q <= '0;
      prefix_phys_q <= '0;
    end else if (state_q == MODE_ENTER) begin
      prefix_log_q <= '0; // [RULE_04]
      prefix_phys_q <= atr_slot_q; // [RULE_05]
    end else if (REG_WR && (REG_ADDR == `OFS_PREFIX) && !compat_q) begin
      prefix_log_q <= REG_WDATA[PREFIX_W-1:0];
      prefix_phys_q <= REG_WDATA[PREFIX_W-1:0];
    end else if (step_ok) begin
      prefix_log_q <= prefix_next(prefix_log_q); // [RULE_02]
      prefix_phys_q <= prefix_next(prefix_phys_q);
    end
  end

  assign PREFIX_LOGICAL = prefix_log_q;
  assign PREFIX_PHYSICAL = prefix_phys_q;

  // Logout stop to storage, suppressed under inhibit
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      logout_q <= 1'b0;
    end else begin
      logout_q <= LOGOUT_STOP_REQ && !inhibit_logout_stop_eff; // [RULE_03] [RULE_01]
    end
  end

  assign LOGOUT_STOP_OUT = logout_q;

  // Storage faults: checkstop in compat mode, interruption otherwise
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      checkstop_q <= 1'b0;
      fault_int_q <= 1'b0;
    end else begin
      if (compat_q && stor_fault) begin
        checkstop_q <= 1'b1; // [RULE_06]
      end else if (EXT_START) begin
        checkstop_q <= 1'b0;
      end
      fault_int_q <= !compat_q && stor_fault; // [RULE_06]
    end
  end

  assign CHECKSTOP = checkstop_q;
  assign STOR_FAULT_INT = fault_int_q;

  // Op code screening
  compat_opcode_check u_opcode (
    .CLK_SYS(CLK_SYS),
    .NRST(NRST),
    .dec_valid(DEC_VALID),
    .opcode(OPCODE),
    .compat(compat_q),
    .reject_q(reject)
  );

  assign INVALID_OP_EXC = reject; // [RULE_18]

  // Status word bits 16-19 routed by mode
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      sys_mask_q <= 4'h0;
      int_code_q <= 4'h0;
    end else if (compat_q) begin
      sys_mask_q <= 4'h0; // [RULE_08]
      int_code_q <= PSW_IN[`PSW_FIELD_HI:`PSW_FIELD_LO];
    end else begin
      sys_mask_q <= PSW_IN[`PSW_FIELD_HI:`PSW_FIELD_LO];
      int_code_q <= 4'h0;
    end
  end

  assign SYS_MASK_EXT = sys_mask_q;
  assign INT_CODE_EXT = int_code_q;

  // Channel answer: elements numbered 0, 1, 2 for first, second, third
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      chan_valid_q <= 1'b0;
      chan_resp_q <= CH_OPERATIONAL;
    end else begin
      chan_valid_q <= CHAN_REQ.valid;
      if (!compat_q) begin
        chan_resp_q <= CH_OPERATIONAL;
      end else begin
        case (CHAN_REQ.element)
          2'h0: chan_resp_q <= (CHAN_REQ.channel <= `CHAN_SEL_MAX) ? CH_OPERATIONAL : CH_NOT_OPER; // [RULE_09]
          2'h1: chan_resp_q <= CH_NOT_OPER; // [RULE_10]
          2'h2: chan_resp_q <= CH_INVALID; // [RULE_10]
          default: chan_resp_q <= CH_INVALID;
        endcase
      end
    end
  end

  assign CHAN_RESP_VALID = chan_valid_q;
  assign CHAN_RESP = chan_resp_q;

  // Storage protection
  compat_key_check u_key (
    .CLK_SYS(CLK_SYS),
    .NRST(NRST),
    .req(KEY_REQ),
    .compat(compat_q),
    .done_q(KEY_DONE),
    .match_q(KEY_MATCH)
  );

  assign IOP_STOP = compat_q; // [RULE_13]

  // Direct control passes through in both modes
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      direct_q <= 8'h00;
    end else begin
      direct_q <= DIRECT_CTL_IN; // [RULE_15]
    end
  end

  assign DIRECT_CTL_OUT = direct_q;

  // Mode events for status: one pulse on entry, one on the cycle the mode is left
  assign enter_evt = (state_q == MODE_ENTER);
  assign leave_evt = ((state_q == MODE_COMPAT) && !compat_flag_q && (INSTR_BOUNDARY || clear_evt)) ||
                     ((state_q == MODE_ENTER) && !compat_flag_q);

  // Sticky status: set wins over write-one-to-clear
  assign events = {reject, !checkstop_q && compat_q && stor_fault, leave_evt, enter_evt};
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      status_q <= 4'h0;
    end else begin
      status_q <= (status_q & ~(wr_status ? REG_WDATA[3:0] : 4'h0)) | events;
    end
  end

  assign IRQ = |(status_q & mask_q);

  // Read data, one cycle after the read strobe
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `OFS_STATUS: rdata_q <= {28'h0, status_q};
        `OFS_MASK: rdata_q <= {28'h0, mask_q};
        `OFS_CONTROL: rdata_q <= {24'h0, control_q[7:`CTL_INHIBIT_LOGOUT_STOP_BIT+1], inhibit_logout_stop_eff,
                                  control_q[`CTL_INHIBIT_LOGOUT_STOP_BIT-1:0]};
        `OFS_PREFIX: rdata_q <= 32'(prefix_log_q);
        `OFS_ATR_SLOT: rdata_q <= 32'(atr_slot_q);
        `OFS_MODE: rdata_q <= {28'h0, checkstop_q, compat_flag_q, compat_q, IOP_STOP};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign REG_RDATA = rdata_q;
endmodule

// ---- verification/compat_mode_monitor.sv ----
// Purpose: concurrent checks on the compatibility-mode gating ports
// Assumes: IOP_STOP mirrors the effective compatibility mode
// Notes: bound to every compat_mode_ctrl instance
`timescale 1ns/1ps
module compat_mode_monitor
  import compat_pkg::*;
#(
  parameter int PREFIX_W = 16
)
(
  // Clock, reset and panel events
  input logic CLK_SYS, NRST, MODE_BUTTON, EXT_START, STATE_TWO, STATE_THREE,
  input logic SYS_LOAD, SYS_RESTART, MODE_LAMP, INSTR_BOUNDARY, IOP_STOP,
  // Decode, prefix and storage faults
  input logic DEC_VALID, INVALID_OP_EXC, PREFIX_STEP_REQ, LOGOUT_STOP_REQ, LOGOUT_STOP_OUT,
  input logic PREF_LOCKOUT, STOR_STOPPED, STOR_FAULT_INT, CHECKSTOP,
  input logic [7:0] OPCODE,
  input logic [PREFIX_W-1:0] PREFIX_LOGICAL,
  // Channels, keys and direct control
  input chan_req_t CHAN_REQ,
  input logic CHAN_RESP_VALID,
  input chan_resp_t CHAN_RESP,
  input key_req_t KEY_REQ,
  input logic KEY_DONE, KEY_MATCH,
  input logic [7:0] DIRECT_CTL_IN, DIRECT_CTL_OUT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // Expected answers worked out from the request in hand
  logic clr_ev;
  logic bad_dec;
  logic key_exp;
  chan_resp_t chan_exp;
  assign clr_ev = EXT_START | STATE_TWO | STATE_THREE | SYS_LOAD | SYS_RESTART;
  assign bad_dec = DEC_VALID & IOP_STOP & (OPCODE inside {8'h01, 8'h02, 8'h03, 8'h0b, 8'h0c,
    8'h0d, 8'h0e, 8'h0f, 8'h52, 8'h9a, 8'h9b, 8'ha0, 8'ha1, 8'hd8});
  assign key_exp = KEY_REQ.prot_key == 4'h0 || KEY_REQ.prot_key == KEY_REQ.stor_key ||
    (!IOP_STOP && KEY_REQ.stor_key == 4'h0);
  assign chan_exp = (CHAN_REQ.element == 2'd2) ? CH_INVALID :
    (CHAN_REQ.element == 2'd0 && CHAN_REQ.channel <= 4'h3) ? CH_OPERATIONAL : CH_NOT_OPER;
  a_logout_gated: assert property (LOGOUT_STOP_OUT |-> $past(LOGOUT_STOP_REQ) && !$past(IOP_STOP))
    else $error("logout stop issued while inhibited");
  a_opcode_barred: assert property (bad_dec |=> INVALID_OP_EXC)
    else $error("barred op code not rejected");
  a_opcode_only: assert property (INVALID_OP_EXC |-> $past(bad_dec))
    else $error("invalid op exception without cause");
  a_enter_prefix: assert property ($rose(IOP_STOP) |=> PREFIX_LOGICAL == '0)
    else $error("logical prefix not cleared on entry");
  a_step_held: assert property (IOP_STOP && $past(IOP_STOP) && PREFIX_STEP_REQ && !INSTR_BOUNDARY
    |=> $stable(PREFIX_LOGICAL))
    else $error("prefix stepped in compat mode");
  a_fault_stop: assert property (IOP_STOP && (PREF_LOCKOUT || STOR_STOPPED) && !EXT_START
    |=> CHECKSTOP && !STOR_FAULT_INT)
    else $error("storage fault did not checkstop");
  a_chan_map: assert property (CHAN_REQ.valid && IOP_STOP && CHAN_REQ.element != 2'd3
    |=> CHAN_RESP_VALID && CHAN_RESP == $past(chan_exp))
    else $error("channel answer wrong in compat mode");
  a_key_rule: assert property (KEY_REQ.valid |=> KEY_DONE && KEY_MATCH == $past(key_exp))
    else $error("key match wrong");
  a_direct_pass: assert property ($past(NRST) |-> DIRECT_CTL_OUT == $past(DIRECT_CTL_IN))
    else $error("direct control altered");
  a_mode_toggle: assert property (MODE_BUTTON && !clr_ev |=> MODE_LAMP != $past(MODE_LAMP))
    else $error("button did not toggle mode");
  a_mode_clear: assert property (clr_ev |=> !MODE_LAMP)
    else $error("clear event left mode set");
  a_mode_follow: assert property (INSTR_BOUNDARY && !MODE_BUTTON && !clr_ev
    |=> IOP_STOP == $past(MODE_LAMP))
    else $error("effective mode did not follow flag");
endmodule
bind compat_mode_ctrl compat_mode_monitor #(.PREFIX_W(PREFIX_W)) mon_i (.CLK_SYS, .NRST, .MODE_BUTTON,
  .EXT_START, .STATE_TWO, .STATE_THREE, .SYS_LOAD, .SYS_RESTART, .MODE_LAMP, .INSTR_BOUNDARY, .IOP_STOP,
  .DEC_VALID, .INVALID_OP_EXC, .PREFIX_STEP_REQ, .LOGOUT_STOP_REQ, .LOGOUT_STOP_OUT, .PREF_LOCKOUT,
  .STOR_STOPPED, .STOR_FAULT_INT, .CHECKSTOP, .OPCODE, .PREFIX_LOGICAL, .CHAN_REQ, .CHAN_RESP_VALID,
  .CHAN_RESP, .KEY_REQ, .KEY_DONE, .KEY_MATCH, .DIRECT_CTL_IN, .DIRECT_CTL_OUT);

// ---- verification/stor_elem_model.sv ----
// Purpose: storage element seen from the gating block
// Assumes: commands come from the bench one cycle at a time
// Notes: a logout stop halts the element until released
`timescale 1ns/1ps
module stor_elem_model (
  // Clock and reset
  input logic CLK_SYS, NRST,
  // Bench commands: bit0 lockout, bit1 stop, bit2 release
  input logic [2:0] cmd,
  // Block side
  input logic LOGOUT_STOP_OUT,
  output logic PREF_LOCKOUT,
  output logic STOR_STOPPED
);
  // Stopped state is sticky, as a halted element stays halted
  always_ff @(posedge CLK_SYS) begin
    if (!NRST || cmd[2]) begin
      PREF_LOCKOUT <= 1'b0;
      STOR_STOPPED <= 1'b0;
    end else begin
      PREF_LOCKOUT <= cmd[0];
      STOR_STOPPED <= STOR_STOPPED | cmd[1] | LOGOUT_STOP_OUT;
    end
  end
endmodule

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the compatibility-mode gating block
// Assumes: read data are compared by a watcher in the cycle after the strobe
// Notes: events share one vector: button, start, two, three, load, restart, boundary, step
`timescale 1ns/1ps
`include "compat_consts.svh"
module tb_top;
  import compat_pkg::*;
  logic CLK_SYS = 1'b0, NRST = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, DEC_VALID = 1'b0, LOGOUT_STOP_REQ = 1'b0;
  logic [3:0] REG_ADDR = 4'h0;
  logic [31:0] REG_WDATA = 32'h0, PSW_IN = 32'h0, REG_RDATA;
  logic [7:0] evt = 8'h00, OPCODE = 8'h00, DIRECT_CTL_IN = 8'h00, DIRECT_CTL_OUT;
  chan_req_t CHAN_REQ = '0;
  key_req_t KEY_REQ = '0;
  chan_resp_t CHAN_RESP;
  logic [2:0] se_cmd = 3'b000;
  logic [3:0] SYS_MASK_EXT, INT_CODE_EXT;
  logic [15:0] PREFIX_LOGICAL, PREFIX_PHYSICAL, address_translator_reg;
  logic MODE_LAMP, INVALID_OP_EXC, LOGOUT_STOP_OUT, PREF_LOCKOUT, STOR_STOPPED, STOR_FAULT_INT, CHECKSTOP;
  logic CHAN_RESP_VALID, KEY_DONE, KEY_MATCH, IOP_STOP, IRQ, rd_d = 1'b0;
  logic [31:0] exp_q[$];
  logic [7:0] bad[14] = '{8'h01, 8'h02, 8'h03, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h52, 8'h9a, 8'h9b,
    8'ha0, 8'ha1, 8'hd8};
  logic [3:0] kv[3] = '{4'h0, 4'h5, 4'h6};
  int errors = 0, checks = 0, seed = 57061;

  always #5 CLK_SYS = ~CLK_SYS;

  compat_mode_ctrl #(.PREFIX_W(16)) compat_mode_ctrl_i (.CLK_SYS, .NRST, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA, .MODE_BUTTON(evt[7]), .EXT_START(evt[6]), .STATE_TWO(evt[5]), .STATE_THREE(evt[4]),
    .SYS_LOAD(evt[3]), .SYS_RESTART(evt[2]), .MODE_LAMP, .INSTR_BOUNDARY(evt[1]), .DEC_VALID, .OPCODE,
    .INVALID_OP_EXC, .PSW_IN, .SYS_MASK_EXT, .INT_CODE_EXT, .PREFIX_STEP_REQ(evt[0]), .PREFIX_LOGICAL,
    .PREFIX_PHYSICAL, .LOGOUT_STOP_REQ, .LOGOUT_STOP_OUT, .PREF_LOCKOUT, .STOR_STOPPED, .STOR_FAULT_INT,
    .CHECKSTOP, .CHAN_REQ, .CHAN_RESP_VALID, .CHAN_RESP, .KEY_REQ, .KEY_DONE, .KEY_MATCH, .IOP_STOP,
    .DIRECT_CTL_IN, .DIRECT_CTL_OUT, .IRQ);
  stor_elem_model stor_elem_model_i (.CLK_SYS, .NRST, .cmd(se_cmd), .LOGOUT_STOP_OUT, .PREF_LOCKOUT,
    .STOR_STOPPED);

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Register port cycles; reads leave their expectation in the queue
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    exp_q.push_back(e);
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge CLK_SYS) begin
    rd_d <= REG_RD;
    if (rd_d) chk("read data", REG_RDATA, exp_q.pop_front());
  end
  // One-cycle pulses on the event vector and storage commands
  task automatic ev(input logic [7:0] v);
    @(posedge CLK_SYS);
    evt <= v;
    @(posedge CLK_SYS);
    evt <= 8'h00;
    #1;
  endtask
  task automatic se(input logic [2:0] c);
    @(posedge CLK_SYS);
    se_cmd <= c;
    @(posedge CLK_SYS);
    se_cmd <= 3'b000;
  endtask
  task automatic dec(input logic [7:0] op, input logic e);
    @(posedge CLK_SYS);
    DEC_VALID <= 1'b1;
    OPCODE <= op;
    @(posedge CLK_SYS);
    DEC_VALID <= 1'b0;
    #1 chk("invalid op", INVALID_OP_EXC, e);
  endtask
  task automatic chan(input logic [1:0] el, input logic [3:0] ch, input chan_resp_t e);
    @(posedge CLK_SYS);
    CHAN_REQ <= '{1'b1, el, ch};
    @(posedge CLK_SYS);
    CHAN_REQ <= '0;
    #1 chk("chan valid", CHAN_RESP_VALID, 1);
    chk("chan resp", CHAN_RESP, e);
  endtask
  task automatic key(input logic [3:0] p, input logic [3:0] s, input logic e);
    @(posedge CLK_SYS);
    KEY_REQ <= '{1'b1, p, s};
    @(posedge CLK_SYS);
    KEY_REQ <= '0;
    #1 chk("key done", KEY_DONE, 1);
    chk("key match", KEY_MATCH, e);
  endtask
  // Mode-dependent behaviour swept in the mode given
  task automatic sweep(input logic cm);
    for (int i = 0; i < 3; i++) for (int j = 0; j < 5; j++)
      chan(2'(i), 4'(j), !cm ? CH_OPERATIONAL : i == 2 ? CH_INVALID : (i == 0 && j < 4) ? CH_OPERATIONAL : CH_NOT_OPER);
    for (int i = 0; i < 3; i++) for (int j = 0; j < 3; j++)
      key(kv[i], kv[j], i == 0 || i == j || (!cm && j == 0));
    for (int i = 0; i < 14; i++) dec(bad[i], cm);
    dec(8'h05, 1'b0);
    @(posedge CLK_SYS);
    PSW_IN <= $random(seed);
    DIRECT_CTL_IN <= 8'($random(seed));
    @(posedge CLK_SYS);
    #1 chk("int code", INT_CODE_EXT, cm ? PSW_IN[19:16] : 4'h0);
    chk("sys mask", SYS_MASK_EXT, cm ? 4'h0 : PSW_IN[19:16]);
    chk("direct", DIRECT_CTL_OUT, DIRECT_CTL_IN);
    @(posedge CLK_SYS);
    LOGOUT_STOP_REQ <= 1'b1;
    @(posedge CLK_SYS);
    LOGOUT_STOP_REQ <= 1'b0;
    #1 chk("logout", LOGOUT_STOP_OUT, !cm);
    repeat (2) @(posedge CLK_SYS);
    #1 chk("fault int", STOR_FAULT_INT, !cm);
    se(3'b100);
  endtask

  // Main sequence
  initial begin
    address_translator_reg = 16'($random(seed));
    repeat (10) @(posedge CLK_SYS);
    NRST <= 1'b1;
    rd(`OFS_MODE, 32'h0);
    rd(4'hf, 32'h0);
    wr(`OFS_ATR_SLOT, {16'h0, address_translator_reg});
    wr(`OFS_MASK, 32'h1);
    wr(`OFS_CONTROL, 32'h1);
    wr(`OFS_PREFIX, 32'h1234);
    ev(8'h01);
    chk("step logical", PREFIX_LOGICAL, 32'h1235);
    chk("step physical", PREFIX_PHYSICAL, 32'h1235);
    sweep(1'b0);
    ev(8'h80);
    chk("lamp", MODE_LAMP, 1);
    ev(8'h02);
    rd(`OFS_MODE, 32'h7);
    chk("logical", PREFIX_LOGICAL, 0);
    chk("physical", PREFIX_PHYSICAL, address_translator_reg);
    chk("iop stop", IOP_STOP, 1);
    chk("irq", IRQ, 1);
    rd(`OFS_CONTROL, 32'h41);
    wr(`OFS_MASK, 32'h0);
    #1 chk("irq masked", IRQ, 0);
    wr(`OFS_STATUS, 32'h1);
    wr(`OFS_MASK, 32'h1);
    #1 chk("irq cleared", IRQ, 0);
    ev(8'h01);
    wr(`OFS_PREFIX, 32'h1234);
    #1 chk("step held", PREFIX_LOGICAL, 0);
    chk("step held phys", PREFIX_PHYSICAL, address_translator_reg);
    sweep(1'b1);
    rd(`OFS_STATUS, 32'h8);
    wr(`OFS_STATUS, 32'h8);
    se(3'b001);
    @(posedge CLK_SYS);
    #1 chk("checkstop", CHECKSTOP, 1);
    rd(`OFS_MODE, 32'hf);
    ev(8'h40);
    ev(8'h02);
    rd(`OFS_MODE, 32'h0);
    rd(`OFS_STATUS, 32'h6);
    for (int k = 0; k < 6; k++) begin
      ev(8'h80);
      ev(8'h02);
      ev(8'h80 >> k);
      chk("lamp clear", MODE_LAMP, 0);
      ev(8'h02);
      rd(`OFS_MODE, 32'h0);
    end
    repeat (3) @(posedge CLK_SYS);
    wrap_up;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    errors++;
    wrap_up;
  end
endmodule
